// ==== inc/pwt_consts.svh ====
`ifndef PWT_CONSTS_SVH
`define PWT_CONSTS_SVH

// timebase figures, each in its own unit
`define PWT_CLK_PERIOD_NS      50
`define PWT_FINE_STEP_FS       78125
`define PWT_COARSE_NS          5
`define PWT_PER_STEP_NS        20
`define PWT_DEAD_STEP_PS       1250
`define PWT_MAX_FREQ_KHZ       2000
`define PWT_MAX_WIDTH_COARSE   2048

// derived counts in interpolator steps, except the minimum period code, which is in 20 ns period steps
`define PWT_FINE_PER_CLK       (`PWT_CLK_PERIOD_NS * 1000000 / `PWT_FINE_STEP_FS)
`define PWT_FINE_PER_COARSE    (`PWT_COARSE_NS * 1000000 / `PWT_FINE_STEP_FS)
`define PWT_FINE_PER_PSTEP     (`PWT_PER_STEP_NS * 1000000 / `PWT_FINE_STEP_FS)
`define PWT_FINE_PER_DSTEP     (`PWT_DEAD_STEP_PS * 1000 / `PWT_FINE_STEP_FS)
`define PWT_MIN_PER_CODE       (1000000 / `PWT_MAX_FREQ_KHZ / `PWT_PER_STEP_NS)

// register byte offsets
`define PWT_REG_CTRL           8'h00
`define PWT_REG_PERIOD         8'h04
`define PWT_REG_WIDTH          8'h08
`define PWT_REG_DEAD           8'h0C
`define PWT_REG_SYNC_CFG       8'h10
`define PWT_REG_SYNC_THR       8'h14
`define PWT_REG_STATUS         8'h18

// field positions
`define PWT_CTRL_RUN           0
`define PWT_CTRL_INIT_DONE     1
`define PWT_CTRL_MAPPED        2
`define PWT_CFG_MODE_LSB       16
`define PWT_CFG_LOOP_SEL       18
`define PWT_ST_LOCKED          0
`define PWT_ST_FAULT           1
`define PWT_ST_SEL_VALID       2
`define PWT_ST_SEL_LSB         4

// reset values
`define PWT_RST_PERIOD         16'h0FA0
`define PWT_RST_WIDTH          17'h00000

// bus answers
`define PWT_RESP_OKAY          2'h0
`define PWT_RESP_SLVERR        2'h2

`endif

// ==== inc/pwt_pkg.sv ====
package pwt_pkg;

	typedef enum logic [1:0] {
		PWT_SYNC_OFF = 2'h0,
		PWT_SYNC_IN  = 2'h1,
		PWT_SYNC_OUT = 2'h2
	} pwt_sync_mode_t;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        aw_ok;
		logic        w_ok;
		logic [7:0]  waddr;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        wr_en;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rpend;
		logic [7:0]  raddr;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} pwt_axi_st_t;

	typedef struct packed {
		logic        prev;
		logic        seen;
		logic [15:0] cnt;
		logic [15:0] meas;
		logic        valid;
	} pwt_meter_st_t;

	typedef struct packed {
		logic           run;
		logic           init_done;
		logic           mapped;
		logic [15:0]    per_req;
		logic [16:0]    width;
		logic [15:0]    dead;
		logic [15:0]    pin_mask;
		pwt_sync_mode_t mode;
		logic           loop_sel;
		logic [19:0]    thr;
		logic [19:0]    ph;
		logic [19:0]    sh_per;
		logic [19:0]    sh_width;
		logic [11:0]    sh_dr;
		logic [11:0]    sh_df;
		logic [19:0]    lock_per;
		logic           locked;
		logic           fault;
		logic           pwm_hi;
		logic           pwm_lo;
		logic           pwm_oe_n;
		logic [15:0]    pin_out;
		logic [15:0]    pin_oe_n;
		logic           loop1_sync;
	} pwt_core_st_t;

endpackage

// ==== inc/pwt_reg_if.sv ====
`timescale 1ns/1ps
interface pwt_reg_if;
	logic        wr_en;
	logic [7:0]  wr_addr;
	logic [31:0] wr_data;
	logic [3:0]  wr_strb;
	logic        wr_err;
	logic [7:0]  rd_addr;
	logic [31:0] rd_data;
	logic        rd_err;

	modport bus (output wr_en, wr_addr, wr_data, wr_strb, rd_addr,
		input wr_err, rd_data, rd_err);
	modport regs (input wr_en, wr_addr, wr_data, wr_strb, rd_addr,
		output wr_err, rd_data, rd_err);
endinterface

// ==== rtl/pwt_axi_slave.sv ====
`timescale 1ns/1ps
`include "pwt_consts.svh"
module pwt_axi_slave (
	input  wire logic        clock,
	input  wire logic        nrst,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	pwt_reg_if.bus           rb
);
	pwt_pkg::pwt_axi_st_t s_r;
	pwt_pkg::pwt_axi_st_t s_nxt;

	// address and data may arrive in either order; the answer waits for both
	always_comb begin
		s_nxt = s_r;
		s_nxt.wr_en = 1'b0;
		if (s_axi_awvalid && s_r.awready) begin
			s_nxt.aw_ok = 1'b1;
			s_nxt.waddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_r.wready) begin
			s_nxt.w_ok  = 1'b1;
			s_nxt.wdata = s_axi_wdata;
			s_nxt.wstrb = s_axi_wstrb;
		end
		if (s_r.aw_ok && s_r.w_ok && !s_r.bvalid) begin
			s_nxt.wr_en  = 1'b1;
			s_nxt.bvalid = 1'b1;
			s_nxt.bresp  = rb.wr_err ? `PWT_RESP_SLVERR : `PWT_RESP_OKAY;
			s_nxt.aw_ok  = 1'b0;
			s_nxt.w_ok   = 1'b0;
		end
		if (s_r.bvalid && s_axi_bready)
			s_nxt.bvalid = 1'b0;
		// one read at a time; data is sampled a cycle after the address lands
		if (s_axi_arvalid && s_r.arready) begin
			s_nxt.rpend = 1'b1;
			s_nxt.raddr = s_axi_araddr;
		end
		if (s_r.rpend) begin
			s_nxt.rpend  = 1'b0;
			s_nxt.rvalid = 1'b1;
			s_nxt.rdata  = rb.rd_err ? 32'h00000000 : rb.rd_data;
			s_nxt.rresp  = rb.rd_err ? `PWT_RESP_SLVERR : `PWT_RESP_OKAY;
		end
		if (s_r.rvalid && s_axi_rready)
			s_nxt.rvalid = 1'b0;
		s_nxt.awready = !s_nxt.aw_ok && !s_nxt.bvalid;
		s_nxt.wready  = !s_nxt.w_ok && !s_nxt.bvalid;
		s_nxt.arready = !s_nxt.rpend && !s_nxt.rvalid;
	end

	always_ff @(posedge clock) begin
		if (!nrst) begin
			s_r         <= '0;
			s_r.awready <= 1'b1;
			s_r.wready  <= 1'b1;
			s_r.arready <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign s_axi_awready = s_r.awready;
	assign s_axi_wready  = s_r.wready;
	assign s_axi_bvalid  = s_r.bvalid;
	assign s_axi_bresp   = s_r.bresp;
	assign s_axi_arready = s_r.arready;
	assign s_axi_rvalid  = s_r.rvalid;
	assign s_axi_rdata   = s_r.rdata;
	assign s_axi_rresp   = s_r.rresp;
	assign rb.wr_en      = s_r.wr_en;
	assign rb.wr_addr    = s_r.waddr;
	assign rb.wr_data    = s_r.wdata;
	assign rb.wr_strb    = s_r.wstrb;
	assign rb.rd_addr    = s_r.raddr;
endmodule

// ==== rtl/pwt_engine.sv ====
// Summary of operation
// - edges placed on 78.125 ps interpolator grid
// - period held as eleven-bit count of 20 ns steps
// - pulse width capped at 2048 coarse steps
// - period in 20 ns steps, 2 MHz max
// - period not multiple of step truncates down
// - both switches off during dead interval
// - rising edge delayed 0 to 318.75 ns
// - falling edge adjustable for extra blanking
// - dead-time changes apply while running
// - pwm pair high impedance until initialization done; the sync output pin is not gated by it
// - mapped outputs driven low after initialization
// - clock pin works as input or output
// - any pin selectable as clock pin
// - lowest numbered selected pin wins as input
// - sync input drives lock, either loop
// - lock held within 12.5 percent drift
// - sync output set at ramp threshold crossing
// - lock status and sync fault reported
`timescale 1ns/1ps
`include "pwt_consts.svh"
module pwt_engine #(
	parameter int PER_W   = 11,
	parameter int DEAD_W  = 8,
	parameter int NUM_PIN = 16
) (
	input  wire logic               clock,
	input  wire logic               nrst,
	input  wire logic [7:0]         s_axi_awaddr,
	input  wire logic               s_axi_awvalid,
	output logic                    s_axi_awready,
	input  wire logic [31:0]        s_axi_wdata,
	input  wire logic [3:0]         s_axi_wstrb,
	input  wire logic               s_axi_wvalid,
	output logic                    s_axi_wready,
	output logic [1:0]              s_axi_bresp,
	output logic                    s_axi_bvalid,
	input  wire logic               s_axi_bready,
	input  wire logic [7:0]         s_axi_araddr,
	input  wire logic               s_axi_arvalid,
	output logic                    s_axi_arready,
	output logic [31:0]             s_axi_rdata,
	output logic [1:0]              s_axi_rresp,
	output logic                    s_axi_rvalid,
	input  wire logic               s_axi_rready,
	input  wire logic [NUM_PIN-1:0] sync_pin_in,
	output logic [NUM_PIN-1:0]      sync_pin_out,
	output logic [NUM_PIN-1:0]      sync_pin_oe_n,
	output logic                    pwm_hi_out,
	output logic                    pwm_hi_oe_n,
	output logic                    pwm_lo_out,
	output logic                    pwm_lo_oe_n,
	output logic                    loop1_sync_pulse,
	output logic                    sync_locked,
	output logic                    sync_fault
);
	// the engine is built for the documented field widths only
	if (PER_W != 11 || DEAD_W != 8 || NUM_PIN != 16) begin : g_bad_param
		$error("pwt_engine: PER_W must be 11, DEAD_W 8, NUM_PIN 16");
	end

	// fine-step figures, exact at this clock
	localparam logic [19:0] FINE_CLK  = 20'(`PWT_FINE_PER_CLK);
	localparam logic [15:0] STEP_NS   = 16'(`PWT_PER_STEP_NS);
	localparam logic [15:0] MIN_CODE  = 16'(`PWT_MIN_PER_CODE);
	localparam logic [15:0] MAX_CODE  = 16'((1 << PER_W) - 1);
	localparam logic [19:0] FINE_PSTP = 20'(`PWT_FINE_PER_PSTEP);
	localparam logic [11:0] FINE_DSTP = 12'(`PWT_FINE_PER_DSTEP);
	localparam logic [19:0] MAX_WIDTH = 20'(`PWT_MAX_WIDTH_COARSE * `PWT_FINE_PER_COARSE);

	pwt_reg_if rb ();

	pwt_pkg::pwt_core_st_t s_r;
	pwt_pkg::pwt_core_st_t s_nxt;

	logic        meas_valid;
	logic [15:0] meas;
	logic [15:0] running;
	logic [3:0]  sel_idx;
	logic        sel_valid;
	logic        sel_level;

	// bus front end, then the edge meter
	pwt_axi_slave u_axi (
		.clock         (clock),
		.nrst          (nrst),
		.s_axi_awaddr  (s_axi_awaddr),
		.s_axi_awvalid (s_axi_awvalid),
		.s_axi_awready (s_axi_awready),
		.s_axi_wdata   (s_axi_wdata),
		.s_axi_wstrb   (s_axi_wstrb),
		.s_axi_wvalid  (s_axi_wvalid),
		.s_axi_wready  (s_axi_wready),
		.s_axi_bresp   (s_axi_bresp),
		.s_axi_bvalid  (s_axi_bvalid),
		.s_axi_bready  (s_axi_bready),
		.s_axi_araddr  (s_axi_araddr),
		.s_axi_arvalid (s_axi_arvalid),
		.s_axi_arready (s_axi_arready),
		.s_axi_rdata   (s_axi_rdata),
		.s_axi_rresp   (s_axi_rresp),
		.s_axi_rvalid  (s_axi_rvalid),
		.s_axi_rready  (s_axi_rready),
		.rb            (rb)
	);

	pwt_sync_meter u_meter (
		.clock      (clock),
		.nrst       (nrst),
		.level      (sel_level),
		.meas_valid (meas_valid),
		.meas       (meas),
		.running    (running)
	);

	// truncate a requested period in ns to whole 20 ns steps, then clamp
	function automatic logic [19:0] per_fine(input logic [15:0] req);
		logic [15:0] code;
		code = req / STEP_NS;
		if (code < MIN_CODE)
			code = MIN_CODE;
		if (code > MAX_CODE)
			code = MAX_CODE;
		return 20'(code) * FINE_PSTP;
	endfunction

	// byte-lane merge for a write
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] strb);
		logic [31:0] m;
		m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
		return (old & ~m) | (d & m);
	endfunction

	function automatic logic hit(input logic [7:0] a);
		return a == `PWT_REG_CTRL || a == `PWT_REG_PERIOD || a == `PWT_REG_WIDTH ||
			a == `PWT_REG_DEAD || a == `PWT_REG_SYNC_CFG || a == `PWT_REG_SYNC_THR ||
			a == `PWT_REG_STATUS;
	endfunction

	// lowest set bit of the pin mask picks the clock pin
	always_comb begin
		sel_idx   = 4'h0;
		sel_valid = 1'b0;
		for (int i = NUM_PIN - 1; i >= 0; i--) begin
			if (s_r.pin_mask[i]) begin
				sel_idx   = 4'(i);
				sel_valid = 1'b1;
			end
		end
		// no selected pin reads as low
		sel_level = sel_valid && sync_pin_in[sel_idx];
	end

	// register read mux; unmapped addresses answer with an error
	always_comb begin
		rb.rd_err  = !hit(rb.rd_addr);
		rb.wr_err  = !hit(rb.wr_addr);
		rb.rd_data = 32'h00000000;
		unique case (rb.rd_addr)
			`PWT_REG_CTRL:
				rb.rd_data = {29'h0, s_r.mapped, s_r.init_done, s_r.run};
			`PWT_REG_PERIOD:
				rb.rd_data = {s_r.sh_per[19:8], 4'h0, s_r.per_req};
			`PWT_REG_WIDTH:
				rb.rd_data = {15'h0, s_r.width};
			`PWT_REG_DEAD:
				rb.rd_data = {16'h0, s_r.dead};
			`PWT_REG_SYNC_CFG:
				rb.rd_data = {13'h0, s_r.loop_sel, s_r.mode, s_r.pin_mask};
			`PWT_REG_SYNC_THR:
				rb.rd_data = {12'h0, s_r.thr};
			`PWT_REG_STATUS:
				rb.rd_data = {24'h0, sel_idx, 1'b0, sel_valid, s_r.fault, s_r.locked};
			default:
				rb.rd_data = 32'h00000000;
		endcase
	end

	// whole engine next state: registers, ramp, pulse pair, sync lock
	always_comb begin
		logic [31:0] w;
		logic [19:0] per_eff;
		logic [19:0] nph;
		logic [19:0] wid;
		logic [20:0] lo_start;
		logic [25:0] meas_fine;
		logic [25:0] diff;
		logic [25:0] tol;
		logic        in_mode;
		logic        loop0;
		// locals start cleared so no path latches
		per_eff = '0;
		nph = '0;
		wid = '0;
		lo_start = '0;
		meas_fine = '0;
		diff = '0;
		tol = '0;
		in_mode = 1'b0;
		loop0 = 1'b0;
		s_nxt = s_r;
		w = 32'h00000000;
		s_nxt.loop1_sync = 1'b0;
		if (rb.wr_en) begin
			unique case (rb.wr_addr)
				`PWT_REG_CTRL: begin
					w = merge({29'h0, s_r.mapped, s_r.init_done, s_r.run},
						rb.wr_data, rb.wr_strb);
					s_nxt.run       = w[`PWT_CTRL_RUN];
					s_nxt.init_done = w[`PWT_CTRL_INIT_DONE];
					s_nxt.mapped    = w[`PWT_CTRL_MAPPED];
				end
				`PWT_REG_PERIOD: begin
					w = merge({16'h0, s_r.per_req}, rb.wr_data, rb.wr_strb);
					s_nxt.per_req = w[15:0];
				end
				`PWT_REG_WIDTH: begin
					w = merge({15'h0, s_r.width}, rb.wr_data, rb.wr_strb);
					s_nxt.width = w[16:0];
				end
				`PWT_REG_DEAD: begin
					w = merge({16'h0, s_r.dead}, rb.wr_data, rb.wr_strb);
					s_nxt.dead = w[15:0];
				end
				`PWT_REG_SYNC_CFG: begin
					w = merge({13'h0, s_r.loop_sel, s_r.mode, s_r.pin_mask},
						rb.wr_data, rb.wr_strb);
					s_nxt.pin_mask = w[15:0];
					s_nxt.loop_sel = w[`PWT_CFG_LOOP_SEL];
					unique case (w[`PWT_CFG_MODE_LSB +: 2])
						2'h1:    s_nxt.mode = pwt_pkg::PWT_SYNC_IN;
						2'h2:    s_nxt.mode = pwt_pkg::PWT_SYNC_OUT;
						default: s_nxt.mode = pwt_pkg::PWT_SYNC_OFF;
					endcase
				end
				`PWT_REG_SYNC_THR: begin
					w = merge({12'h0, s_r.thr}, rb.wr_data, rb.wr_strb);
					s_nxt.thr = w[19:0];
				end
				`PWT_REG_STATUS: begin
					// fault is write-one-to-clear; a new fault below overrides
					if (rb.wr_strb[0] && rb.wr_data[`PWT_ST_FAULT])
						s_nxt.fault = 1'b0;
				end
				default: ;
			endcase
		end

		// the locked period steers loop 0 only
		in_mode = s_r.mode == pwt_pkg::PWT_SYNC_IN;
		loop0   = !s_r.loop_sel;
		per_eff = (s_r.locked && loop0) ? s_r.lock_per : s_r.sh_per;

		// ramp in interpolator steps; 640 steps pass per 50 ns clock
		nph = s_r.ph + FINE_CLK;
		wid = (20'(s_r.width) > MAX_WIDTH) ? MAX_WIDTH : 20'(s_r.width);
		if (!s_r.run || nph >= per_eff) begin
			// new settings only at a period boundary, so no runt pulse
			s_nxt.ph       = s_r.run ? nph - per_eff : 20'h00000;
			s_nxt.sh_per   = per_fine(s_r.per_req);
			s_nxt.sh_width = wid;
			s_nxt.sh_dr    = 12'(s_r.dead[7:0]) * FINE_DSTP;
			s_nxt.sh_df    = 12'(s_r.dead[15:8]) * FINE_DSTP;
		end else begin
			s_nxt.ph = nph;
		end

		// high side: rising edge delayed, falling edge pulled in
		s_nxt.pwm_hi = s_r.run && s_r.init_done &&
			(s_r.ph >= 20'(s_r.sh_dr)) &&
			(21'(s_r.ph) + 21'(s_r.sh_df) < 21'(s_r.sh_width));
		// low side waits its own dead time after the high side falls
		lo_start = 21'(s_r.sh_width) + 21'(s_r.sh_dr);
		s_nxt.pwm_lo = s_r.run && s_r.init_done &&
			(21'(s_r.ph) >= lo_start) &&
			(21'(s_r.ph) + 21'(s_r.sh_df) < 21'(per_eff));
		// pair floats until firmware marks setup done and the pair mapped
		s_nxt.pwm_oe_n = !(s_r.init_done && s_r.mapped);

		// sync output: high from threshold crossing to end of period
		s_nxt.pin_out  = '0;
		s_nxt.pin_oe_n = '1;
		if (s_r.mode == pwt_pkg::PWT_SYNC_OUT && sel_valid) begin
			s_nxt.pin_oe_n[sel_idx] = 1'b0;
			s_nxt.pin_out[sel_idx]  = s_r.run && s_r.init_done &&
				(s_nxt.ph >= s_r.thr);
		end

		// sync input: compare measured period against programmed period
		meas_fine = 26'(meas) * 26'(FINE_CLK);
		diff = (meas_fine > 26'(s_r.sh_per)) ? meas_fine - 26'(s_r.sh_per) :
			26'(s_r.sh_per) - meas_fine;
		// wider window once locked, narrow window to acquire
		tol = s_r.locked ? 26'(s_r.sh_per >> 3) : 26'(s_r.sh_per >> 4);
		if (!in_mode || !sel_valid) begin
			s_nxt.locked = 1'b0;
		end else if (meas_valid) begin
			if (diff <= tol) begin
				s_nxt.locked   = 1'b1;
				s_nxt.lock_per = meas_fine[19:0];
				// loop 0 restarts its ramp on a lock
				if (loop0)
					s_nxt.ph = 20'h00000;
				else
					s_nxt.loop1_sync = 1'b1;
			end else begin
				// cannot acquire, or drifted out after lock
				s_nxt.locked = 1'b0;
				s_nxt.fault  = 1'b1;
			end
		end else if (26'(running) * 26'(FINE_CLK) > {5'h0, s_r.sh_per, 1'b0}) begin
			// no edge for two programmed periods: the source is gone
			s_nxt.locked = 1'b0;
			s_nxt.fault  = 1'b1;
		end
	end

	// single stage for all state
	always_ff @(posedge clock) begin
		if (!nrst) begin
			s_r          <= '0;
			s_r.per_req  <= `PWT_RST_PERIOD;
			s_r.width    <= `PWT_RST_WIDTH;
			s_r.pwm_oe_n <= 1'b1;
			s_r.pin_oe_n <= '1;
		end else begin
			s_r <= s_nxt;
		end
	end

	// outputs leave straight from flops
	assign pwm_hi_out       = s_r.pwm_hi;
	assign pwm_hi_oe_n      = s_r.pwm_oe_n;
	assign pwm_lo_out       = s_r.pwm_lo;
	assign pwm_lo_oe_n      = s_r.pwm_oe_n;
	assign sync_pin_out     = s_r.pin_out;
	assign sync_pin_oe_n    = s_r.pin_oe_n;
	assign loop1_sync_pulse = s_r.loop1_sync;
	assign sync_locked      = s_r.locked;
	assign sync_fault       = s_r.fault;
endmodule

// ==== rtl/pwt_sync_meter.sv ====
`timescale 1ns/1ps
module pwt_sync_meter (
	input  wire logic        clock,
	input  wire logic        nrst,
	input  wire logic        level,
	output logic             meas_valid,
	output logic [15:0]      meas,
	output logic [15:0]      running
);
	pwt_pkg::pwt_meter_st_t s_r;
	pwt_pkg::pwt_meter_st_t s_nxt;

	// rising edge to rising edge, in clock cycles; the first edge only arms
	always_comb begin
		s_nxt = s_r;
		s_nxt.valid = 1'b0;
		s_nxt.prev  = level;
		if (s_r.cnt != 16'hFFFF)
			s_nxt.cnt = s_r.cnt + 16'h0001;
		if (level && !s_r.prev) begin
			s_nxt.valid = s_r.seen;
			s_nxt.meas  = s_nxt.cnt;
			s_nxt.seen  = 1'b1;
			s_nxt.cnt   = 16'h0000;
		end
	end

	always_ff @(posedge clock) begin
		if (!nrst)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	assign meas_valid = s_r.valid;
	assign meas       = s_r.meas;
	assign running    = s_r.cnt;
endmodule

// ==== test/pwt_engine_monitor.sv ====
`timescale 1ns/1ps
module pwt_engine_monitor #(
	parameter int NUM_PIN = 16
) (
	input wire logic               clock,
	input wire logic               nrst,
	input wire logic               s_axi_awvalid,
	input wire logic               s_axi_awready,
	input wire logic               s_axi_wvalid,
	input wire logic               s_axi_wready,
	input wire logic               s_axi_bvalid,
	input wire logic               s_axi_arvalid,
	input wire logic               s_axi_arready,
	input wire logic               s_axi_rvalid,
	input wire logic [NUM_PIN-1:0] sync_pin_oe_n,
	input wire logic               pwm_hi_out,
	input wire logic               pwm_hi_oe_n,
	input wire logic               pwm_lo_out,
	input wire logic               pwm_lo_oe_n,
	input wire logic               loop1_sync_pulse,
	input wire logic               sync_locked,
	input wire logic               sync_fault
);
	// single domain, so clock and reset are given once
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!nrst);

	// request steps of the two bus directions
	sequence wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence rd_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence

	wr_resp_a: assert property (wr_taken |-> ##2 s_axi_bvalid)
		else $error("write answer not two cycles after request");
	rd_resp_a: assert property (rd_taken |-> ##2 s_axi_rvalid)
		else $error("read answer not two cycles after request");
	wr_gate_a: assert property (wr_taken |=> !s_axi_awready && !s_axi_wready)
		else $error("write readies still high after take");
	rd_gate_a: assert property (rd_taken |=> !s_axi_arready)
		else $error("read ready still high after take");
	shoot_thru_a: assert property (!(pwm_hi_out && pwm_lo_out))
		else $error("both switches on");
	hiz_reset_a: assert property ($rose(nrst) |-> &{pwm_hi_oe_n, pwm_lo_oe_n, sync_pin_oe_n})
		else $error("output driven across reset");
	drive_low_a: assert property ($fell(pwm_hi_oe_n) |-> !pwm_hi_out && !pwm_lo_out)
		else $error("output not low when first driven");
	pin_one_a: assert property ($onehot0(~sync_pin_oe_n))
		else $error("more than one clock pin driven");
	fault_lock_a: assert property ($rose(sync_fault) |-> !sync_locked)
		else $error("lock kept while fault raised");
	pulse_one_a: assert property (loop1_sync_pulse |=> !loop1_sync_pulse)
		else $error("loop sync pulse longer than one cycle");
endmodule

// ==== test/pwt_stage_model.sv ====
`timescale 1ns/1ps
module pwt_stage_model (
	input wire logic        clock,
	input wire logic        on,
	input wire logic [7:0]  per,
	input wire logic [15:0] pin_out,
	input wire logic [15:0] pin_oe_n,
	output logic [15:0]     level
);
	logic [7:0] cnt = 8'h00;
	logic [1:0] dec = 2'h0;

	// source period comes from the bench, near the programmed one
	always @(posedge clock) begin
		cnt <= (!on || cnt >= per - 8'h01) ? 8'h00 : cnt + 8'h01;
		dec <= (dec == 2'h2) ? 2'h0 : dec + 2'h1;
	end

	// idle pins fall to their pull-down; pin 5 carries a fast decoy
	always_comb begin
		level = 16'h0000;
		level[3] = on && (cnt < (per >> 1));
		level[5] = on && (dec == 2'h0);
		for (int i = 0; i < 16; i++) begin
			if (!pin_oe_n[i])
				level[i] = pin_out[i];
		end
	end
endmodule

// ==== test/tb.sv ====
`timescale 1ns/1ps
`include "pwt_consts.svh"
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin err_count++; \
	$display("unexpected %s expected %h seen %h", n, e, g); end end
module tb;
	typedef struct {logic [31:0] d; logic [31:0] m; logic [1:0] r; bit rd;} pwt_exp_t;
	logic        clock = 1'b0, nrst = 1'b0;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [15:0] sync_pin_in, sync_pin_out, sync_pin_oe_n;
	logic        pwm_hi_out, pwm_hi_oe_n, pwm_lo_out, pwm_lo_oe_n;
	logic        loop1_sync_pulse, sync_locked, sync_fault, src_on = 1'b0;
	logic [7:0]  src_per = 8'h14;
	logic [31:0] seed = 32'h5;
	logic [15:0] pr[3] = '{16'hEA60, 16'h0064, 16'h03F2};
	logic [11:0] pc[3] = '{12'h7FF, 12'h019, 12'h032};
	int          err_count = 0, compares = 0, cyc = 0, pulses = 0, p0, n;
	pwt_exp_t    exp_q[$];

	always #25 clock = ~clock;

	pwt_engine u_pwt_engine (.*);
	pwt_stage_model u_pwt_stage_model (.clock(clock), .on(src_on), .per(src_per),
		.pin_out(sync_pin_out), .pin_oe_n(sync_pin_oe_n), .level(sync_pin_in));

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction

	task automatic summarize();
		$display("compares %0d err_count %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// hang guard, well above the expected run length
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_count++;
			summarize();
		end
	end

	always @(posedge clock) begin
		if (loop1_sync_pulse === 1'b1)
			pulses <= pulses + 1;
	end

	// oldest note is matched against each bus answer as it is taken
	always @(posedge clock) begin
		pwt_exp_t e;
		if ((s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready)) begin
			e = exp_q.pop_front();
			if (e.rd) begin
				`CHK("rdata", e.d, s_axi_rdata & e.m)
				`CHK("rresp", e.r, s_axi_rresp)
			end else
				`CHK("bresp", e.r, s_axi_bresp)
		end
	end

	// one bus transfer; readiness sampled mid-cycle so it equals the edge value
	task automatic xfer(input bit is_rd, input logic [7:0] a, input logic [31:0] d,
		input logic [31:0] m, input logic [1:0] r);
		bit ta, tw, tr, done;
		exp_q.push_back('{d & m, m, r, is_rd});
		@(posedge clock);
		if (is_rd) begin
			s_axi_araddr <= a;
			s_axi_arvalid <= 1'b1;
			s_axi_rready <= 1'b1;
		end else begin
			s_axi_awaddr <= a;
			s_axi_wdata <= d;
			s_axi_awvalid <= 1'b1;
			s_axi_wvalid <= 1'b1;
			s_axi_bready <= 1'b1;
		end
		done = 0;
		while (!done) begin
			@(negedge clock);
			ta = (s_axi_awvalid && s_axi_awready) || (s_axi_arvalid && s_axi_arready);
			tw = s_axi_wvalid && s_axi_wready;
			tr = s_axi_bvalid || s_axi_rvalid;
			@(posedge clock);
			if (ta) begin
				s_axi_awvalid <= 1'b0;
				s_axi_arvalid <= 1'b0;
			end
			if (tw)
				s_axi_wvalid <= 1'b0;
			if (tr) begin
				s_axi_bready <= 1'b0;
				s_axi_rready <= 1'b0;
				done = 1;
			end
		end
	endtask

	// one full switching period from a rising high-side edge
	task automatic pwm(input int eh, input int el, input int ep);
		int h, l, p;
		h = 0;
		l = 0;
		p = 0;
		@(negedge clock);
		while (pwm_hi_out !== 1'b0) @(negedge clock);
		while (pwm_hi_out !== 1'b1) @(negedge clock);
		while (pwm_hi_out === 1'b1) begin
			h++;
			p++;
			l += pwm_lo_out;
			@(negedge clock);
		end
		while (pwm_hi_out !== 1'b1) begin
			p++;
			l += pwm_lo_out;
			@(negedge clock);
		end
		`CHK("high", eh, h)
		`CHK("low", el, l)
		`CHK("period", ep, p)
	endtask

	initial begin
		repeat (10) @(posedge clock);
		nrst <= 1'b1;
		@(negedge clock);
		`CHK("oe_n", 3'h7, {pwm_hi_oe_n, pwm_lo_oe_n, &sync_pin_oe_n})
		xfer(1, `PWT_REG_PERIOD, 32'h0C800FA0, 32'hFFF0FFFF, `PWT_RESP_OKAY);
		for (int i = 0; i < 3; i++) begin
			xfer(0, `PWT_REG_PERIOD, {16'h0, pr[i]}, 32'h0, `PWT_RESP_OKAY);
			xfer(1, `PWT_REG_PERIOD, {pc[i], 4'h0, pr[i]}, 32'hFFF0FFFF, `PWT_RESP_OKAY);
		end
		xfer(0, `PWT_REG_WIDTH, 32'hFFFFFFFF, 32'h0, `PWT_RESP_OKAY);
		xfer(1, `PWT_REG_WIDTH, 32'h0001FFFF, 32'hFFFFFFFF, `PWT_RESP_OKAY);
		xfer(0, `PWT_REG_WIDTH, 32'h1900, 32'h0, `PWT_RESP_OKAY);
		for (int i = 0; i < 3; i++) begin
			seed = xs(seed);
			xfer(0, `PWT_REG_SYNC_THR, seed, 32'h0, `PWT_RESP_OKAY);
			xfer(1, `PWT_REG_SYNC_THR, seed, 32'h000FFFFF, `PWT_RESP_OKAY);
		end
		xfer(1, 8'h1C, 32'h0, 32'hFFFFFFFF, `PWT_RESP_SLVERR);
		xfer(0, 8'h20, 32'h0, 32'h0, `PWT_RESP_SLVERR);
		xfer(0, `PWT_REG_CTRL, 32'h6, 32'h0, `PWT_RESP_OKAY);
		repeat (2) @(negedge clock);
		`CHK("drive", 4'h0, {pwm_hi_oe_n, pwm_lo_oe_n, pwm_hi_out, pwm_lo_out})
		xfer(0, `PWT_REG_CTRL, 32'h7, 32'h0, `PWT_RESP_OKAY);
		pwm(10, 10, 20);
		xfer(0, `PWT_REG_DEAD, 32'h0028, 32'h0, `PWT_RESP_OKAY);
		repeat (20) @(posedge clock);
		pwm(9, 9, 20);
		xfer(0, `PWT_REG_DEAD, 32'h2828, 32'h0, `PWT_RESP_OKAY);
		repeat (20) @(posedge clock);
		pwm(8, 8, 20);
		// sync input on pins 3 and 5, source first too far off to acquire
		src_per <= 8'd22;
		src_on <= 1'b1;
		xfer(0, `PWT_REG_SYNC_CFG, 32'h00010028, 32'h0, `PWT_RESP_OKAY);
		repeat (300) @(posedge clock);
		xfer(1, `PWT_REG_STATUS, 32'h36, 32'hF7, `PWT_RESP_OKAY);
		src_per <= 8'd21;
		repeat (300) @(posedge clock);
		xfer(0, `PWT_REG_STATUS, 32'h2, 32'h0, `PWT_RESP_OKAY);
		repeat (100) @(posedge clock);
		xfer(1, `PWT_REG_STATUS, 32'h35, 32'hF7, `PWT_RESP_OKAY);
		@(negedge clock);
		`CHK("locked", 1'b1, sync_locked)
		xfer(0, `PWT_REG_SYNC_CFG, 32'h00050028, 32'h0, `PWT_RESP_OKAY);
		repeat (100) @(posedge clock);
		p0 = pulses;
		repeat (210) @(posedge clock);
		`CHK("pulses", 10, pulses - p0)
		src_per <= 8'd22;
		repeat (300) @(posedge clock);
		xfer(1, `PWT_REG_STATUS, 32'h35, 32'hF7, `PWT_RESP_OKAY);
		src_per <= 8'd24;
		repeat (300) @(posedge clock);
		xfer(1, `PWT_REG_STATUS, 32'h36, 32'hF7, `PWT_RESP_OKAY);
		pwm(8, 8, 20);
		// sync output on pin 2, phase set by the threshold
		src_on <= 1'b0;
		xfer(0, `PWT_REG_SYNC_THR, 32'h1900, 32'h0, `PWT_RESP_OKAY);
		xfer(0, `PWT_REG_SYNC_CFG, 32'h00020004, 32'h0, `PWT_RESP_OKAY);
		repeat (40) @(posedge clock);
		`CHK("sync_oe_n", 16'hFFFB, sync_pin_oe_n)
		n = 0;
		repeat (20) begin
			@(negedge clock);
			n += sync_pin_out[2];
		end
		`CHK("sync_high", 10, n)
		summarize();
	end
endmodule

bind pwt_engine pwt_engine_monitor #(.NUM_PIN(NUM_PIN)) u_pwt_engine_monitor (.*);
